// file: logic/hbc_pkg.sv
// Package with offsets, field positions, reset values and codes of the bridge header
package hbc_pkg;
   localparam logic [15:0] HBC_IO_ADDR_PORT  = 16'h0CF8;
   localparam logic [15:0] HBC_IO_DATA_PORT  = 16'h0CFC;
   localparam logic [7:0]  HBC_OFS_MAKER     = 8'h00;
   localparam logic [7:0]  HBC_OFS_PART      = 8'h02;
   localparam logic [7:0]  HBC_OFS_COMMAND   = 8'h04;
   localparam logic [7:0]  HBC_OFS_STATUS    = 8'h06;
   localparam logic [7:0]  HBC_OFS_CLASS     = 8'h08;
   localparam logic [7:0]  HBC_OFS_HEADER    = 8'h0C;
   localparam logic [7:0]  HBC_OFS_CONTROL   = 8'h50;
   localparam logic [7:0]  HBC_OFS_ERRSTAT   = 8'h54;
   localparam logic [7:0]  HBC_BUS_NUM       = 8'h00;
   localparam logic [4:0]  HBC_DEV_NUM       = 5'h0B;
   localparam logic [2:0]  HBC_FUNC_NUM      = 3'h0;
   localparam int          HBC_IDSEL_BASE    = 11;
   localparam int          HBC_IDSEL_COUNT   = 21;
   localparam int          HBC_ADDR_ENABLE   = 31;
   localparam int          HBC_BUS_HI        = 23;
   localparam int          HBC_BUS_LO        = 16;
   localparam int          HBC_DEV_HI        = 15;
   localparam int          HBC_DEV_LO        = 11;
   localparam int          HBC_FUNC_HI       = 10;
   localparam int          HBC_FUNC_LO       = 8;
   localparam int          HBC_REG_HI        = 7;
   localparam int          HBC_REG_LO        = 2;
   localparam logic [31:0] HBC_ADDR_MASK     = 32'h80FFFFFC;
   localparam logic [31:0] HBC_ADDR_RESET    = 32'h00000000;
   localparam int          HBC_CMD_ERR_EN    = 8;
   localparam logic [15:0] HBC_CMD_FIXED     = 16'h0007;
   localparam logic [15:0] HBC_STATUS_RESET  = 16'h0280;
   localparam logic [31:0] HBC_CONTROL_RESET = 32'h00000000;
   localparam logic [31:0] HBC_ERRSTAT_RESET = 32'h00000000;
   // Arbitrary neutral identity codes
   localparam logic [15:0] HBC_MAKER_CODE    = 16'h1234;
   localparam logic [15:0] HBC_PART_CODE     = 16'h5678;
endpackage

// file: logic/hbc_cfg_if.sv
// Interface carrying header register accesses from the IO decoder to the header bank
`timescale 1ns/1ps
interface hbc_cfg_if;
   logic        rd;
   logic        wr;
   logic [5:0]  dword;
   logic [3:0]  be;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        err_en;
   modport master (output rd, output wr, output dword, output be, output wdata,
                   input rdata, input err_en);
   modport slave  (input rd, input wr, input dword, input be, input wdata,
                   output rdata, output err_en);
endinterface

// file: logic/hbc_header.sv
// Header register bank of the host bridge: identifiers, command and fixed registers
`timescale 1ns/1ps
module hbc_header (
   input  wire logic   clk_in,
   input  wire logic   rst_b_in,
   hbc_cfg_if.slave    cfg
);
   import hbc_pkg::*;

   logic        err_en_r;
   logic [31:0] ctrl_r;
   logic [31:0] errstat_r;
   logic [7:0]  ofs;
   logic [31:0] rd_mux;

   assign ofs = {cfg.dword, 2'b00};
   // Identifier words are constants, so writes never reach them
   assign rd_mux = (ofs == HBC_OFS_MAKER)   ? {HBC_PART_CODE, HBC_MAKER_CODE} :
                   (ofs == HBC_OFS_COMMAND) ? {HBC_STATUS_RESET,
                                               7'h00, err_en_r, HBC_CMD_FIXED[7:0]} :
                   (ofs == HBC_OFS_CONTROL) ? ctrl_r :
                   (ofs == HBC_OFS_ERRSTAT) ? errstat_r :
                   32'h00000000;
   assign cfg.rdata  = rd_mux;
   assign cfg.err_en = err_en_r;

   // Only bit 8 of the command word is storage; control and error status hold reset values
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         err_en_r  <= 1'b0;
         ctrl_r    <= HBC_CONTROL_RESET;
         errstat_r <= HBC_ERRSTAT_RESET;
      end else if (cfg.wr && ofs == HBC_OFS_COMMAND && cfg.be[1]) begin
         err_en_r  <= cfg.wdata[HBC_CMD_ERR_EN];
      end
   end
endmodule

// file: logic/hbc_top.sv
// Host bridge configuration header: address and data ports and config cycle decode
`timescale 1ns/1ps
// Summary of operation
// - The data window is a 32-bit port read and written by byte, word or dword IO cycles.
// - The bridge answers config accesses to bus 0, device 0Bh, function 0 on select line 11.
// - The maker code is a 16-bit constant at offsets 0h-1h and ignores writes.
// - The part code is a 16-bit constant at offsets 2h-3h and ignores writes.
// - After reset the command register reads 0007h.
// - Command bit 8 gates the system error line for abort and parity events.
// - Command bits 15 to 9 read zero and ignore writes.
// - Command bits 7, 5, 4 and 3 read zero and ignore writes.
// - Command bits 2, 1 and 0 read one and ignore writes.
// - Control and error status registers read zero after reset.
// - With address bit 31 set, window cycles become config cycles, else normal IO.
// - In a type-0 cycle the device number field drives the matching select line.
module hbc_top (
   input  wire logic                           clk_in,
   input  wire logic                           rst_b_in,
   input  wire logic                           io_rd_in,
   input  wire logic                           io_wr_in,
   input  wire logic [15:0]                    io_addr_in,
   input  wire logic [3:0]                     io_be_in,
   input  wire logic [31:0]                    io_wdata_in,
   input  wire logic                           target_abort_in,
   input  wire logic                           master_abort_in,
   input  wire logic                           cfg_space_in,
   input  wire logic                           parity_err_in,
   output logic [31:0]                         io_rdata_out,
   output logic                                io_ack_out,
   output logic                                io_pass_out,
   output logic                                cfg_cycle_out,
   output logic [31:0]                         cfg_ad_out,
   output logic [hbc_pkg::HBC_IDSEL_COUNT-1:0] idsel_out,
   output logic                                serr_b_out
);
   import hbc_pkg::*;

   hbc_cfg_if cfg ();

   logic [31:0] addr_r;
   logic [31:0] rdata_r;
   logic        ack_r;
   logic        pass_r;
   logic        cyc_r;
   logic [31:0] ad_r;
   logic [HBC_IDSEL_COUNT-1:0] idsel_r;
   logic        serr_b_r;

   wire         hit_addr;
   wire         hit_data;
   wire         cfg_on;
   wire         self_hit;
   wire         err_event;
   wire         bus_zero;
   wire         win_cfg;
   wire [31:0]  lane_mask;
   wire [31:0]  read_val;
   wire [HBC_IDSEL_COUNT-1:0] idsel_dec;

   // Expand byte enables to a bit mask
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   assign hit_addr  = io_addr_in[15:2] == HBC_IO_ADDR_PORT[15:2] && io_be_in == 4'hF;
   assign hit_data  = io_addr_in[15:2] == HBC_IO_DATA_PORT[15:2];
   assign cfg_on    = addr_r[HBC_ADDR_ENABLE];
   assign self_hit  = cfg_on && addr_r[HBC_BUS_HI:HBC_BUS_LO] == HBC_BUS_NUM
                      && addr_r[HBC_DEV_HI:HBC_DEV_LO] == HBC_DEV_NUM
                      && addr_r[HBC_FUNC_HI:HBC_FUNC_LO] == HBC_FUNC_NUM;
   assign lane_mask = be_mask(io_be_in);
   assign read_val  = hit_addr ? addr_r
                    : (hit_data && self_hit) ? (cfg.rdata & lane_mask)
                    : 32'h00000000;
   // Only type-0 cycles on bus 0 fan out to a select line
   // Device numbers past the last select line decode to no line at all
   assign bus_zero  = addr_r[HBC_BUS_HI:HBC_BUS_LO] == HBC_BUS_NUM;
   for (genvar n = 0; n < HBC_IDSEL_COUNT; n++) begin : g_idsel
      assign idsel_dec[n] = bus_zero && addr_r[HBC_DEV_HI:HBC_DEV_LO] == 5'(n);
   end
   assign err_event = target_abort_in || (master_abort_in && !cfg_space_in)
                      || parity_err_in;
   assign win_cfg   = (io_rd_in || io_wr_in) && hit_data && cfg_on;

   assign cfg.rd    = io_rd_in && hit_data && self_hit;
   assign cfg.wr    = io_wr_in && hit_data && self_hit;
   assign cfg.dword = addr_r[HBC_REG_HI:HBC_REG_LO];
   assign cfg.be    = io_be_in;
   assign cfg.wdata = io_wdata_in & lane_mask;

   hbc_header u_header (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .cfg      (cfg)
   );

   // Reserved address bits are masked on write so they read back as zero
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         addr_r <= HBC_ADDR_RESET;
      end else if (io_wr_in && hit_addr) begin
         addr_r <= io_wdata_in & HBC_ADDR_MASK;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_r  <= 32'h00000000;
         ack_r    <= 1'b0;
         pass_r   <= 1'b0;
         cyc_r    <= 1'b0;
         ad_r     <= 32'h00000000;
         idsel_r  <= '0;
      end else begin
         rdata_r  <= io_rd_in ? read_val : 32'h00000000;
         ack_r    <= (io_rd_in || io_wr_in) && (hit_addr || (hit_data && cfg_on));
         pass_r   <= (io_rd_in || io_wr_in) && hit_data && !cfg_on;
         cyc_r    <= win_cfg;
         ad_r     <= {8'h00, addr_r[HBC_BUS_HI:HBC_BUS_LO],
                      5'h00, addr_r[HBC_FUNC_HI:HBC_FUNC_LO], addr_r[HBC_REG_HI:0]};
         idsel_r  <= win_cfg ? idsel_dec : '0;
      end
   end

   // Low in the cycle after each event cycle, for as long as the event lasts, blocked while the enable bit is clear
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         serr_b_r <= 1'b1;
      end else begin
         serr_b_r <= !(cfg.err_en && err_event);
      end
   end

   assign io_rdata_out  = rdata_r;
   assign io_ack_out    = ack_r;
   assign io_pass_out   = pass_r;
   assign cfg_cycle_out = cyc_r;
   assign cfg_ad_out    = ad_r;
   assign idsel_out     = idsel_r;
   assign serr_b_out    = serr_b_r;

   a_serr_gated: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !cfg.err_en |=> serr_b_out) else $error("system error while disabled");
   a_serr_fires: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg.err_en && parity_err_in |=> !serr_b_out) else $error("parity not signalled");
   a_cmd_fixed: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg.dword == 6'h01 |-> cfg.rdata[15:9] == 7'h00 && cfg.rdata[7:0] == 8'h07)
      else $error("command fixed bits wrong");
   a_ids_const: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg.dword == 6'h00 |-> cfg.rdata == {HBC_PART_CODE, HBC_MAKER_CODE})
      else $error("identifier word changed");
   a_pass_mode: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      io_rd_in && hit_data && !cfg_on |=> io_pass_out && !cfg_cycle_out)
      else $error("window cycle not passed through");
   a_idsel_one: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      io_rd_in && hit_data && cfg_on && addr_r[23:11] == 13'h000B |=> idsel_out[11])
      else $error("select line 11 not driven");
   a_lane_only: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      io_rd_in && hit_data && io_be_in == 4'h1 |=> io_rdata_out[31:8] == 24'h000000)
      else $error("unselected lanes returned");
   a_other_dev: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      io_rd_in && hit_data && !self_hit |=> io_rdata_out == 32'h00000000)
      else $error("answered foreign device");
   a_win_claim: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg.rd |=> io_ack_out && cfg_cycle_out && !io_pass_out)
      else $error("window read not claimed");
   a_win_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg.wr && !io_rd_in |=> io_ack_out && cfg_cycle_out && io_rdata_out == 32'h00000000)
      else $error("window write not claimed");
   a_rd_foreign: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      io_rd_in && hit_data && cfg_on && !self_hit |=> io_ack_out && cfg_cycle_out)
      else $error("foreign config cycle not forwarded");
   a_addr_ack: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      io_wr_in && hit_addr |=> io_ack_out && !cfg_cycle_out)
      else $error("address write not claimed");
   a_addr_resv: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (addr_r & ~HBC_ADDR_MASK) == 32'h00000000)
      else $error("reserved address bits set");
   a_addr_keep: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !(io_wr_in && hit_addr) |=> $stable(addr_r))
      else $error("address register changed without a write");
   a_pass_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      io_wr_in && hit_data && !cfg_on |=> io_pass_out && !io_ack_out)
      else $error("window write not passed through");
   a_serr_target: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg.err_en && target_abort_in |=> !serr_b_out)
      else $error("target abort not signalled");
   a_serr_master: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg.err_en && master_abort_in && !cfg_space_in |=> !serr_b_out)
      else $error("master abort not signalled");
   a_serr_quiet: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !target_abort_in && !parity_err_in && !(master_abort_in && !cfg_space_in) |=> serr_b_out)
      else $error("system error without an event");
   a_idsel_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !cfg_cycle_out |-> idsel_out == '0)
      else $error("select line outside a config cycle");
   a_idsel_onehot: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      $onehot0(idsel_out))
      else $error("more than one select line");
   a_ad_fields: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg_cycle_out |-> cfg_ad_out[31:24] == 8'h00 && cfg_ad_out[15:11] == 5'h00
                        && cfg_ad_out[1:0] == 2'b00) else $error("address phase fields wrong");
   a_rd_idle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !io_rd_in |=> io_rdata_out == 32'h00000000)
      else $error("read data without a read");
   a_cmd_stored: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg.wr && cfg.dword == HBC_OFS_COMMAND[7:2] && cfg.be[1]
      |=> cfg.err_en == $past(cfg.wdata[HBC_CMD_ERR_EN])) else $error("enable bit not stored");
   a_cmd_kept: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !(cfg.wr && cfg.dword == HBC_OFS_COMMAND[7:2] && cfg.be[1]) |=> $stable(cfg.err_en))
      else $error("enable bit changed without its lane");
   a_ctrl_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg.dword == HBC_OFS_CONTROL[7:2] || cfg.dword == HBC_OFS_ERRSTAT[7:2] |-> cfg.rdata == 0)
      else $error("control or error status not zero");
   a_part_code: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cfg.dword == 6'h00 |-> cfg.rdata[31:16] == HBC_PART_CODE)
      else $error("part code changed");
endmodule

// file: tb/hbc_host_model.sv
// Host processor model issuing configuration IO cycles
`timescale 1ns/1ps
module hbc_host_model (
   input  wire logic        clk_in,
   output logic             io_rd_out,
   output logic             io_wr_out,
   output logic [15:0]      io_addr_out,
   output logic [3:0]       io_be_out,
   output logic [31:0]      io_wdata_out
);
   initial begin
      io_rd_out    = 1'b0;
      io_wr_out    = 1'b0;
      io_addr_out  = 16'h0000;
      io_be_out    = 4'h0;
      io_wdata_out = 32'h00000000;
   end
   // One cycle per call; released lines show the inverse so stale values never match
   task automatic cycle(input logic wr, input logic [15:0] a, input logic [3:0] be,
                        input logic [31:0] d);
      @(posedge clk_in);
      io_rd_out    <= !wr;
      io_wr_out    <= wr;
      io_addr_out  <= a;
      io_be_out    <= be;
      io_wdata_out <= d;
      @(posedge clk_in);
      io_rd_out    <= 1'b0;
      io_wr_out    <= 1'b0;
      io_addr_out  <= ~a;
      io_be_out    <= ~be;
      io_wdata_out <= ~d;
      #1;
   endtask
endmodule

// file: tb/host_bridge_config_header_tb_top.sv
// Self-checking bench of the bridge configuration header
`timescale 1ns/1ps
module host_bridge_config_header_tb_top;
   import hbc_pkg::*;
   logic        clk_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic        ab_t = 1'b0, ab_m = 1'b0, cfg_sp = 1'b0, par_e = 1'b0;
   logic        io_rd, io_wr, ack, pass, cyc, serr_b;
   logic [15:0] io_addr, cmd_m;
   logic [3:0]  io_be;
   logic [31:0] io_wdata, rdata, ad, r, seed = 32'hA9A35AAF;
   logic [20:0] idsel;
   logic [7:0]  ofs_l [6] = '{HBC_OFS_MAKER, HBC_OFS_COMMAND, HBC_OFS_CLASS,
                              HBC_OFS_HEADER, HBC_OFS_CONTROL, HBC_OFS_ERRSTAT};
   logic [3:0]  be_l [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
   logic [3:0]  ev_l [4] = '{4'h8, 4'h4, 4'h6, 4'h1};
   int          err_total = 0, checks_done = 0;
   always #5 clk_in = ~clk_in;
   hbc_host_model hbc_host_model_i (.clk_in(clk_in), .io_rd_out(io_rd), .io_wr_out(io_wr),
      .io_addr_out(io_addr), .io_be_out(io_be), .io_wdata_out(io_wdata));
   hbc_top hbc_top_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .io_rd_in(io_rd),
      .io_wr_in(io_wr), .io_addr_in(io_addr), .io_be_in(io_be), .io_wdata_in(io_wdata),
      .target_abort_in(ab_t), .master_abort_in(ab_m), .cfg_space_in(cfg_sp),
      .parity_err_in(par_e), .io_rdata_out(rdata), .io_ack_out(ack), .io_pass_out(pass),
      .cfg_cycle_out(cyc), .cfg_ad_out(ad), .idsel_out(idsel), .serr_b_out(serr_b));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] expect_hdr(logic [7:0] ofs, logic [3:0] be);
      logic [31:0] v;
      v = (ofs == HBC_OFS_MAKER) ? {HBC_PART_CODE, HBC_MAKER_CODE} :
          (ofs == HBC_OFS_COMMAND) ? {HBC_STATUS_RESET, cmd_m} : 32'h0;
      return v & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic point(input logic [31:0] a);
      hbc_host_model_i.cycle(1'b1, HBC_IO_ADDR_PORT, 4'hF, a);
      check(32'(ack), 32'h1);
   endtask
   task automatic hdr_rd(input logic [7:0] ofs, input logic [3:0] be);
      point(32'h80005800 | 32'(ofs));
      hbc_host_model_i.cycle(1'b0, HBC_IO_DATA_PORT, be, rnd());
      check(rdata, expect_hdr(ofs, be));
      check(32'({ack, cyc, pass}), 32'h6);
      check(32'(idsel), 32'h800);
      check(ad, 32'(ofs));
   endtask
   task automatic hdr_wr(input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] d);
      point(32'h80005800 | 32'(ofs));
      hbc_host_model_i.cycle(1'b1, HBC_IO_DATA_PORT, be, d & 32'hFFFFFFBF);
      if (ofs == HBC_OFS_COMMAND && be[1])
         cmd_m[8] = d[8];
   endtask
   // Event bits are target abort, master abort, config space, parity
   task automatic err_ev(input logic [3:0] ev, input logic low);
      @(posedge clk_in);
      {ab_t, ab_m, cfg_sp, par_e} <= ev;
      @(posedge clk_in);
      {ab_t, ab_m, cfg_sp, par_e} <= 4'h0;
      #1;
      check(32'(serr_b), 32'(!low));
   endtask
   initial begin
      #200000;
      err_total++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge clk_in);
      rst_b_in <= 1'b1;
      cmd_m = HBC_CMD_FIXED;
      foreach (ofs_l[i]) hdr_rd(ofs_l[i], 4'hF);
      hdr_wr(HBC_OFS_COMMAND, 4'hF, 32'hFFFFFFFF);
      hdr_rd(HBC_OFS_COMMAND, 4'h3);
      hdr_wr(HBC_OFS_MAKER, 4'hF, 32'h0);
      hdr_rd(HBC_OFS_MAKER, 4'hF);
      repeat (60) begin
         r = rnd();
         hdr_wr(ofs_l[r[7:0] % 6], be_l[r[15:8] % 7], rnd());
         hdr_rd(ofs_l[r[23:16] % 6], be_l[r[31:24] % 7]);
      end
      for (int s = 0; s < 2; s++) begin
         hdr_wr(HBC_OFS_COMMAND, 4'h2, 32'(s) << 8);
         foreach (ev_l[i]) err_ev(ev_l[i], s == 1 && ev_l[i] != 4'h6);
      end
      point(32'h80006000);
      hbc_host_model_i.cycle(1'b0, HBC_IO_DATA_PORT, 4'hF, 32'h0);
      check(rdata, 32'h0);
      check(32'(idsel), 32'h1000);
      point(32'h00005800);
      hbc_host_model_i.cycle(1'b0, HBC_IO_DATA_PORT, 4'hF, 32'h0);
      check(32'({ack, cyc, pass}), 32'h1);
      hbc_host_model_i.cycle(1'b1, HBC_IO_ADDR_PORT, 4'h3, rnd());
      check(32'(ack), 32'h0);
      hbc_host_model_i.cycle(1'b0, HBC_IO_ADDR_PORT, 4'hF, rnd());
      check(rdata, 32'h00005800);
      point(32'hFF0158FF);
      hbc_host_model_i.cycle(1'b0, HBC_IO_ADDR_PORT, 4'hF, rnd());
      check(rdata, 32'hFF0158FF & HBC_ADDR_MASK);
      hbc_host_model_i.cycle(1'b0, HBC_IO_DATA_PORT, 4'hF, rnd());
      check(32'({idsel, cyc, rdata == 32'h0}), 32'h3);
      summarize();
   end
endmodule
